//--- hw/mc_match.sv
// Constants of the multicast classifier and its address match stage.
// Assumes one clock domain; the match stage is purely combinational.
//
// Operation
// [R1] Up to 64 groups per partition
// [R2] Group capability resets to 32, reprogrammable to 64
// [R3] Only posted writes, address messages qualify
// [R4] Enable clear means nothing is multicast
// [R5] Non-multicast packets take unicast routing
// [R6] Multicast keeps posted ordering, nothing extra
// [R7] Same error, poison, CRC handling as others
// [R8] Membership decided from packet address alone
// [R9] Regions contiguous, ascending, from group zero
// [R10] No region beyond the enabled group count
// [R11] Each region spans two power exponent bytes
// [R12] Software programs identical config across partition
// [R13] One register set decides for partition
// [R14] Software quiesces traffic before config change
// [R15] Multicast never leaves its own partition
// [R16] Sender membership irrelevant to classification
// [R17] Overlap: non-posted requests stay unicast
// [R18] Base is 64 bits, low and high
// [R19] Zero low and group bits, compare base
// [R20] Group number from address at exponent
// [R21] Group above enabled count means unicast
// [R22] Verdict and group travel with packet
`timescale 1ns/100ps
`default_nettype none

package mc_pkg;
  localparam int ADDR_W = 64;
  localparam int DATA_W = 32;
  localparam int REG_AW = 8;
  localparam int GRP_W  = 6;
  localparam int SH_W   = 7;
  localparam int CNT_W  = 16;
  // Register byte offsets
  localparam logic [7:0] OFS_CAP  = 8'h00;
  localparam logic [7:0] OFS_CTL  = 8'h04;
  localparam logic [7:0] OFS_BLO  = 8'h08;
  localparam logic [7:0] OFS_BHI  = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_CNT  = 8'h14;
  // Field positions and reset values
  localparam int EN_BIT    = 31;
  localparam int BLO_LSB   = 12;
  localparam int VERD_BIT  = 8;
  localparam int UC_LSB    = 16;
  localparam logic [5:0] MAXGRP_RST = 6'h1F;
  localparam logic [5:0] GRP_ZERO   = 6'h00;

  typedef enum logic [2:0] {
    KIND_MWR     = 3'b000,
    KIND_MSG_ADR = 3'b001,
    KIND_MRD     = 3'b010,
    KIND_IO      = 3'b011,
    KIND_CFG     = 3'b100,
    KIND_CPL     = 3'b101,
    KIND_MSG_OTH = 3'b110,
    KIND_OTHER   = 3'b111
  } pkt_kind_t;

  // Address bits holding the group number: ceil(log2(count + 1))
  function automatic logic [6:0] group_bits(input logic [5:0] num);
    logic [6:0] n1;
    logic [6:0] b;
    n1 = {1'b0, num} + 7'h01;
    b  = 7'h00;
    for (int i = 0; i < 7; i++)
      if ((7'h01 << i) < n1) b = 7'(i + 1);
    return b;
  endfunction

  // Group number field of an address
  function automatic logic [5:0] group_of(input logic [63:0] addr,
                                          input logic [5:0]  expo,
                                          input logic [6:0]  nb);
    logic [63:0] s;
    logic [63:0] m;
    s = addr >> expo;
    m = ~({64{1'b1}} << nb);
    return s[5:0] & m[5:0];
  endfunction

  function automatic logic eligible(input pkt_kind_t k);
    return (k == KIND_MWR) || (k == KIND_MSG_ADR);
  endfunction
endpackage

module mc_match
(
  input  wire mc_pkg::pkt_kind_t kind,
  input  wire logic [63:0]       addr,
  input  wire logic              enable,
  input  wire logic [5:0]        num_groups,
  input  wire logic [5:0]        expo,
  input  wire logic [63:0]       base,
  output logic                   hit,
  output logic [5:0]             group
);
  import mc_pkg::*;

  logic [6:0]  nb;
  logic [6:0]  sh;
  logic [63:0] keep;
  logic        base_eq;

  // Bits below exponent plus group field are ignored in the compare
  always_comb
  begin
    nb      = group_bits(num_groups);            // see [R20]
    sh      = {1'b0, expo} + nb;                 // see [R11]
    keep    = {64{1'b1}} << sh;
    base_eq = ((addr ^ base) & keep) == 64'h0;   // see [R19]
    group   = group_of(addr, expo, nb);          // see [R9]
    // Verdict gathers type, enable, address and range terms
    hit     = enable                             // see [R4]
            & eligible(kind)                     // see [R3], [R17]
            & base_eq                            // see [R8]
            & (group <= num_groups);             // see [R21]
  end
endmodule

`default_nettype wire

//--- hw/mc_classifier.sv
// Multicast classifier top: registers, one-stage verdict pipeline.
// Assumes packets come from logic on ref_clk, one per cycle at most,
// and software quiesces multicast traffic while it reprograms.
`timescale 1ns/100ps
`default_nettype none

module mc_classifier
#(
  parameter int TAG_W  = 8,
  parameter int PART_W = 2,
  parameter int ERR_W  = 3
)
(
  input  wire logic                        ref_clk,
  input  wire logic                        sys_rst,
  input  wire logic [mc_pkg::REG_AW-1:0]   reg_addr,
  input  wire logic [mc_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [mc_pkg::DATA_W-1:0]   reg_rdata,
  input  wire logic                        in_valid,
  input  wire mc_pkg::pkt_kind_t           in_kind,
  input  wire logic [mc_pkg::ADDR_W-1:0]   in_addr,
  input  wire logic [TAG_W-1:0]            in_tag,
  input  wire logic [PART_W-1:0]           in_partition,
  input  wire logic [ERR_W-1:0]            in_err,
  output logic                             out_valid,
  output logic                             out_mcast,
  output logic      [mc_pkg::GRP_W-1:0]    out_group,
  output logic      [mc_pkg::ADDR_W-1:0]   out_addr,
  output logic      [TAG_W-1:0]            out_tag,
  output logic      [PART_W-1:0]           out_partition,
  output logic      [ERR_W-1:0]            out_err
);
  import mc_pkg::*;

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  logic [5:0]  max_group_count_q;
  logic [5:0]  enabled_group_count_q;
  logic        multicast_enable_bit_q;
  logic [5:0]  region_size_exponent_q;
  logic [31:0] multicast_base_low_q;
  logic [31:0] multicast_base_high_q;
  logic [63:0] base_addr;
  logic [5:0]  wr_count;
  logic        hit;
  logic [5:0]  group;
  logic        wr_cap;
  logic        wr_ctl;
  logic        wr_blo;
  logic        wr_bhi;

  assign wr_cap = reg_wr && (reg_addr == OFS_CAP);
  assign wr_ctl = reg_wr && (reg_addr == OFS_CTL);
  assign wr_blo = reg_wr && (reg_addr == OFS_BLO);
  assign wr_bhi = reg_wr && (reg_addr == OFS_BHI);

  // Base is one 64-bit value; bits below the low field read zero
  assign base_addr = {multicast_base_high_q,
                      multicast_base_low_q[31:BLO_LSB],
                      {BLO_LSB{1'b0}}};                  // see [R18]

  // Enabled count written above the advertised maximum is clamped to it
  assign wr_count = (reg_wdata[5:0] > max_group_count_q)
                  ? max_group_count_q : reg_wdata[5:0];

  // Capability: advertises 32 groups, reprogrammable up to 64
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      max_group_count_q <= MAXGRP_RST;                  // see [R2]
    else if (wr_cap)
      max_group_count_q <= reg_wdata[5:0];              // see [R1]
  end

  // Control: enable bit and enabled group count
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      multicast_enable_bit_q <= 1'b0;
      enabled_group_count_q  <= GRP_ZERO;
    end
    else if (wr_ctl)
    begin
      multicast_enable_bit_q <= reg_wdata[EN_BIT];      // see [R4]
      enabled_group_count_q  <= wr_count;               // see [R10]
    end
  end

  // Base address halves and region size exponent
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      region_size_exponent_q <= GRP_ZERO;
      multicast_base_low_q   <= 32'h0000_0000;
      multicast_base_high_q  <= 32'h0000_0000;
    end
    else
    begin
      if (wr_blo)
      begin
        region_size_exponent_q <= reg_wdata[5:0];       // see [R11]
        multicast_base_low_q   <= {reg_wdata[31:BLO_LSB], {BLO_LSB{1'b0}}};
      end
      if (wr_bhi)
        multicast_base_high_q <= reg_wdata;             // see [R18]
    end
  end

  // ------------------------------------------------------------
  // Address match
  // ------------------------------------------------------------
  // One register set serves every port of the partition;
  // no sender identity reaches the match, member or not
  mc_match u_match                                      // see [R13], [R16]
  (
    .kind       (in_kind),
    .addr       (in_addr),
    .enable     (multicast_enable_bit_q),
    .num_groups (enabled_group_count_q),
    .expo       (region_size_exponent_q),
    .base       (base_addr),
    .hit        (hit),
    .group      (group)
  );

  // ------------------------------------------------------------
  // Verdict pipeline
  // ------------------------------------------------------------
  // Valid follows input one cycle later, in arrival order
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      out_valid <= 1'b0;
    else
      out_valid <= in_valid;                            // see [R6]
  end

  // Verdict and group ride with the packet
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      out_mcast <= 1'b0;
      out_group <= GRP_ZERO;
    end
    else
    begin
      out_mcast <= in_valid && hit;                     // see [R22]
      out_group <= (in_valid && hit) ? group : GRP_ZERO; // see [R5]
    end
  end

  // Packet fields pass unchanged; error flags stay for normal checks
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      out_addr      <= 64'h0;
      out_tag       <= '0;
      out_partition <= '0;
      out_err       <= '0;
    end
    else
    begin
      out_addr      <= in_addr;
      out_tag       <= in_tag;
      out_partition <= in_partition;                    // see [R15]
      out_err       <= in_err;                          // see [R7]
    end
  end

  // ------------------------------------------------------------
  // Status and counters
  // ------------------------------------------------------------
  logic [5:0]       last_group_q;
  logic             last_mcast_q;
  logic [CNT_W-1:0] mc_cnt_q;
  logic [CNT_W-1:0] uc_cnt_q;

  // Last verdict seen, for software inspection
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      last_group_q <= GRP_ZERO;
      last_mcast_q <= 1'b0;
    end
    else if (in_valid)
    begin
      last_group_q <= hit ? group : GRP_ZERO;
      last_mcast_q <= hit;
    end
  end

  // Wrapping packet counters, cleared by any write to them
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || (reg_wr && (reg_addr == OFS_CNT)))
    begin
      mc_cnt_q <= '0;
      uc_cnt_q <= '0;
    end
    else if (in_valid)
    begin
      if (hit)
        mc_cnt_q <= mc_cnt_q + 16'h0001;
      else
        uc_cnt_q <= uc_cnt_q + 16'h0001;                // see [R5]
    end
  end

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  logic [31:0] rd_d;

  // Read mux; unmapped offsets answer zero
  always_comb
  begin
    rd_d = 32'h0000_0000;
    case (reg_addr)
      OFS_CAP:  rd_d[5:0] = max_group_count_q;
      OFS_CTL:
      begin
        rd_d[EN_BIT] = multicast_enable_bit_q;
        rd_d[5:0]    = enabled_group_count_q;
      end
      OFS_BLO:
      begin
        rd_d          = multicast_base_low_q;
        rd_d[5:0]     = region_size_exponent_q;
      end
      OFS_BHI:  rd_d = multicast_base_high_q;
      OFS_STAT:
      begin
        rd_d[5:0]      = last_group_q;
        rd_d[VERD_BIT] = last_mcast_q;
      end
      OFS_CNT:  rd_d = {uc_cnt_q, mc_cnt_q};
      default:  rd_d = 32'h0000_0000;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      reg_rdata <= 32'h0000_0000;
    else
      reg_rdata <= reg_rd ? rd_d : 32'h0000_0000;
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // Helper mask: bits above the group field must match the base
  logic [63:0] keep_chk;
  assign keep_chk = {64{1'b1}} << ({1'b0, region_size_exponent_q}
                    + group_bits(enabled_group_count_q));

  sequence s_ctl_off;
    reg_wr && (reg_addr == OFS_CTL) && !reg_wdata[EN_BIT];
  endsequence

  sequence s_pkt_next;
    in_valid;
  endsequence

  a_ineligible_unicast: assert property ( // see [R3]
    in_valid && !eligible(in_kind) |=> !out_mcast)
    else $error("ineligible packet marked multicast");

  a_disable_blocks: assert property ( // see [R4]
    s_ctl_off ##1 s_pkt_next |=> !out_mcast)
    else $error("multicast while disabled");

  a_verdict_latency: assert property ( // see [R22]
    in_valid |=> out_valid && (out_tag == $past(in_tag)))
    else $error("verdict not one cycle after packet");

  a_no_extra_valid: assert property ( // see [R6]
    !in_valid |=> !out_valid && !out_mcast)
    else $error("spurious output packet");

  a_err_passed: assert property ( // see [R7]
    in_valid |=> out_err == $past(in_err))
    else $error("error flags altered");

  a_partition_kept: assert property ( // see [R15]
    in_valid |=> out_partition == $past(in_partition))
    else $error("packet left its partition");

  a_base_mismatch: assert property ( // see [R19]
    in_valid && (((in_addr ^ base_addr) & keep_chk) != 64'h0)
    |=> !out_mcast)
    else $error("mismatched base classified multicast");

  a_group_range: assert property ( // see [R10]
    out_mcast |-> out_group <= $past(enabled_group_count_q))
    else $error("group beyond enabled count");

  a_group_field: assert property ( // see [R20]
    in_valid ##1 out_mcast |-> out_group == group_of($past(in_addr),
      $past(region_size_exponent_q),
      group_bits($past(enabled_group_count_q))))
    else $error("group number taken from wrong bits");

  a_cap_default: assert property ( // see [R2]
    $past(sys_rst) |-> max_group_count_q == MAXGRP_RST)
    else $error("capability reset value wrong");

  a_read_window: assert property (
    !reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data outside its cycle");

  // Verdict bookkeeping: enable gate, unicast group, status, counters
  a_enable_off: assert property ( // see [R4]
    !multicast_enable_bit_q |=> !out_mcast)
    else $error("multicast verdict with enable clear");

  a_unicast_group: assert property ( // see [R5]
    out_valid && !out_mcast |-> out_group == GRP_ZERO)
    else $error("unicast packet carries a group");

  a_status_follows: assert property ( // see [R22]
    in_valid |=> (last_mcast_q == out_mcast) && (last_group_q == out_group))
    else $error("status differs from verdict");

  a_count_clear: assert property (
    reg_wr && (reg_addr == OFS_CNT) |=> (mc_cnt_q == '0) && (uc_cnt_q == '0))
    else $error("counters not cleared by write");

endmodule

`default_nettype wire

//--- sim/pkt_source.sv
// Packet source model standing for the roots and endpoints of one partition.
// Assumes the bench calls send and idle in the time step of a rising edge.
`timescale 1ns/100ps
`default_nettype none

module pkt_source
(
  input  wire logic         ref_clk,
  output logic              in_valid,
  output mc_pkg::pkt_kind_t in_kind,
  output logic [63:0]       in_addr,
  output logic [7:0]        in_tag,
  output logic [1:0]        in_partition,
  output logic [2:0]        in_err
);
  import mc_pkg::*;

  // Quiet lines at time zero
  initial
  begin
    in_valid = 1'b0;
    in_kind = KIND_OTHER;
    in_addr = 64'h0;
    in_tag = 8'h00;
    in_partition = 2'h0;
    in_err = 3'h0;
  end

  // One packet, held until the edge that takes it; sender need not be a member
  task automatic send(input pkt_kind_t k, input logic [63:0] a, input logic [7:0] t,
                      input logic [1:0] p, input logic [2:0] e);
    in_valid <= 1'b1;
    in_kind <= k;
    in_addr <= a;
    in_tag <= t;
    in_partition <= p;
    in_err <= e;
    @(posedge ref_clk);
  endtask

  // Released lines except partition invert on each call; a second idle in a row shows the last packet again
  task automatic idle();
    in_valid <= 1'b0;
    in_kind <= pkt_kind_t'(~in_kind);
    in_addr <= ~in_addr;
    in_tag <= ~in_tag;
    in_err <= ~in_err;
    @(posedge ref_clk);
  endtask
endmodule

`default_nettype wire

//--- sim/test_mc_classifier.sv
// Self-checking bench for the multicast classifier.
// Assumes default parameters and the packet source model beside it.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin mismatches++; \
  $display("wrong value %s expected %0h seen %0h", n, e, a); end end

module test_mc_classifier;
  import mc_pkg::*;
  logic        ref_clk, sys_rst, reg_wr, reg_rd, in_valid, out_valid, out_mcast, en;
  logic [7:0]  reg_addr, in_tag, out_tag;
  logic [31:0] reg_wdata, reg_rdata;
  logic [63:0] in_addr, out_addr, base;
  logic [5:0]  out_group, cnt, expo;
  logic [1:0]  in_partition, out_partition;
  logic [2:0]  in_err, out_err;
  pkt_kind_t   in_kind;
  int          mismatches, checked;
  logic [84:0] expq[$];
  logic [84:0] want;

  mc_classifier mc_classifier_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .in_valid(in_valid), .in_kind(in_kind), .in_addr(in_addr), .in_tag(in_tag),
    .in_partition(in_partition), .in_err(in_err), .out_valid(out_valid),
    .out_mcast(out_mcast), .out_group(out_group), .out_addr(out_addr), .out_tag(out_tag),
    .out_partition(out_partition), .out_err(out_err));

  pkt_source pkt_source_i (.ref_clk(ref_clk), .in_valid(in_valid), .in_kind(in_kind),
    .in_addr(in_addr), .in_tag(in_tag), .in_partition(in_partition), .in_err(in_err));

  // Clock
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // --------------------------------------------------
  // Register and packet tasks
  // --------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    `CHK(n, e, reg_rdata)
    @(posedge ref_clk);
  endtask

  // Expected verdict: inside one of the enabled regions above the base
  task automatic pkt(input pkt_kind_t k, input logic [63:0] a);
    logic [63:0] g;
    logic        hit;
    g = (a - base) >> expo;
    hit = en && (k == KIND_MWR || k == KIND_MSG_ADR) && a >= base && g <= 64'(cnt);
    pkt_source_i.send(k, a, a[9:2], a[13:12], a[16:14]);
    expq.push_back({1'b1, hit, hit ? g[5:0] : 6'h00, a, a[9:2], a[13:12], a[16:14]});
  endtask

  // Every output cycle against the queue, half a cycle after the take
  always @(negedge ref_clk)
    if (!sys_rst)
    begin
      want = (expq.size() > 0) ? expq.pop_front() : 85'h0;
      if (want[84])
        `CHK("packet", want, {out_valid, out_mcast, out_group, out_addr, out_tag,
             out_partition, out_err})
      else
        `CHK("idle", 1'b0, out_valid)
    end

  task automatic summarize();
    $display("compares %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Watchdog, far beyond the fewer than a hundred cycles the tests take
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    mismatches++;
    summarize();
  end

  // --------------------------------------------------
  // Main sequence
  // --------------------------------------------------
  initial
  begin
    sys_rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    en = 1'b0;
    cnt = 6'h00;
    expo = 6'h00;
    base = 64'h0;
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(OFS_CAP, 32'h0000_001F, "cap");
    rd(OFS_CTL, 32'h0, "ctl");
    rd(8'h18, 32'h0, "unmapped");
    // Same values as every other function of the partition, traffic quiet
    wr(OFS_BLO, 32'h8000_000C);
    wr(OFS_BHI, 32'h0000_0001);
    base = 64'h0000_0001_8000_0000;
    expo = 6'h0C;
    rd(OFS_BLO, 32'h8000_000C, "base_lo");
    rd(OFS_BHI, 32'h0000_0001, "base_hi");
    pkt(KIND_MWR, base + 64'h2000);
    pkt_source_i.idle();
    wr(OFS_CTL, 32'h8000_0005);
    en = 1'b1;
    cnt = 6'h05;
    for (int k = 0; k < 8; k++)
      pkt(pkt_kind_t'(k), base + 64'h2010);
    for (int g = 0; g < 9; g++)
      pkt(KIND_MWR, base + (64'(g) << 12) + 64'hFFC);
    pkt(KIND_MSG_ADR, base ^ 64'h0010_0000);
    pkt(KIND_MWR, base - 64'h4);
    pkt(KIND_MWR, base ^ 64'h0000_0002_0000_0000);
    pkt_source_i.idle();
    wr(OFS_CTL, 32'h8000_003F);
    rd(OFS_CTL, 32'h8000_001F, "clamp");
    wr(OFS_CAP, 32'h0000_003F);
    wr(OFS_CTL, 32'h8000_003F);
    rd(OFS_CTL, 32'h8000_003F, "ctl64");
    cnt = 6'h3F;
    pkt(KIND_MWR, base + 64'h3F000);
    pkt(KIND_MRD, base + 64'h3F000);
    pkt(KIND_MWR, base + 64'h3F000);
    pkt_source_i.idle();
    // Last verdict: multicast, group 63
    rd(OFS_STAT, 32'h0000_013F, "stat");
    wr(OFS_CTL, 32'h0000_003F);
    en = 1'b0;
    pkt(KIND_MSG_ADR, base + 64'h1000);
    pkt_source_i.idle();
    pkt_source_i.idle();
    // Ten multicast and fifteen unicast packets since reset
    rd(OFS_CNT, 32'h000F_000A, "counts");
    wr(OFS_CNT, 32'h0);
    rd(OFS_CNT, 32'h0, "count_clear");
    summarize();
  end
endmodule

`default_nettype wire
